/* File: rtl/swd_pay_chk.sv */
// Shared constants for the sideband wire discovery block and its payload checker.
`timescale 1ns/10ps
package swd_pkg;
    localparam int          NT              = 2;          // Targets sharing one initiator.
    localparam int          PAY_BYTES       = 32;         // Stored payload bytes per target.
    localparam int          CLK_HZ          = 125_000_000;
    localparam int          RX_TIMEOUT_S    = 1;          // Payload receive timeout in seconds.
    localparam int          RX_TIMEOUT_CYC  = RX_TIMEOUT_S * CLK_HZ;
    localparam int          RETRIES         = 2;          // Retries after the initial attempt.
    localparam logic [7:0]  PAY_REQ_CMD     = 8'h00;      // Payload request command byte.
    // Discovery state codes.
    localparam logic [1:0]  DS_HIGH         = 2'h0;
    localparam logic [1:0]  DS_LOW          = 2'h1;
    localparam logic [1:0]  DS_GOOD         = 2'h2;
    localparam logic [1:0]  DS_RELEASED     = 2'h3;
    // Payload header layout.
    localparam logic [10:0] HDR_SIZE_IDX    = 11'h002;    // Size in units of 8 bytes.
    localparam logic [10:0] HDR_WIRES_IDX   = 11'h00A;
    localparam logic [10:0] HDR_EPDESC_IDX  = 11'h00B;
    localparam logic [10:0] HDR_RSVD_IDX    = 11'h00C;
    localparam int          WIRES_RSVD_BIT  = 3;
    localparam logic [10:0] PAY_MIN_LEN     = 11'h010;    // 12 + 2 + 1 padded to 8.
    // Register map, byte addresses.
    localparam logic [7:0]  REG_CTRL        = 8'h00;
    localparam logic [7:0]  REG_STATUS      = 8'h04;
    localparam logic [7:0]  REG_PAY_BASE    = 8'h40;
    localparam int          CTRL_FETCH_POS  = 0;
    localparam int          CTRL_ACTIVE_POS = 4;
    localparam int          CTRL_ACCT_POS   = 8;
    localparam int          ST_EXCH_POS     = 8;
    localparam int          ST_BACKFEED_POS = 12;
    localparam int          ST_BUSY_POS     = 16;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SEND = 2'b01,
        SEQ_WAIT = 2'b10
    } swd_seq_t;
endpackage : swd_pkg

module swd_pay_chk (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        start,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_err,
    output logic             done,
    output logic             good,
    output logic [10:0]      idx
);
    import swd_pkg::*;

    logic [10:0] cnt_r, cnt_nxt, len_r, len_nxt;
    logic [7:0]  sum_r, sum_nxt;
    logic        err_r, err_nxt, done_r, done_nxt, good_r, good_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Byte counter, running sum and error tracking for one payload.
    always_comb begin
        cnt_nxt  = cnt_r;
        len_nxt  = len_r;
        sum_nxt  = sum_r;
        err_nxt  = err_r;
        done_nxt = 1'b0;
        good_nxt = 1'b0;
        if (start) begin
            cnt_nxt = '0;
            len_nxt = '0;
            sum_nxt = '0;
            err_nxt = 1'b0;
        end else if (rx_valid) begin
            cnt_nxt = cnt_r + 11'h001;
            sum_nxt = sum_r + rx_byte;
            if (rx_err) begin
                err_nxt = 1'b1;
            end
            if (cnt_r == HDR_SIZE_IDX) begin
                len_nxt = {rx_byte, 3'b000};
                if ({rx_byte, 3'b000} < PAY_MIN_LEN) begin
                    err_nxt = 1'b1;
                end
            end
            if (cnt_r == HDR_WIRES_IDX && rx_byte[WIRES_RSVD_BIT]) begin
                err_nxt = 1'b1;
            end
            if ((cnt_r == HDR_EPDESC_IDX && rx_byte[7:4] != 4'h0) ||
                (cnt_r == HDR_RSVD_IDX && rx_byte != 8'h00)) begin
                err_nxt = 1'b1;
            end
            // length in 8 byte units ends the payload
            if (cnt_r > HDR_SIZE_IDX && cnt_nxt == len_r) begin
                done_nxt = 1'b1;
                good_nxt = (sum_nxt == 8'h00) && !err_r && !rx_err;
            end
        end
    end

    // State registers; clock enable freezes everything.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r  <= '0;
            len_r  <= '0;
            sum_r  <= '0;
            err_r  <= 1'b0;
            done_r <= 1'b0;
            good_r <= 1'b0;
        end else if (ce) begin
            cnt_r  <= cnt_nxt;
            len_r  <= len_nxt;
            sum_r  <= sum_nxt;
            err_r  <= err_nxt;
            done_r <= done_nxt;
            good_r <= good_nxt;
        end
    end

    assign done = done_r;
    assign good = good_r;
    assign idx  = cnt_r;

    chk_good_len_mult8: assert property (@(posedge aclk) disable iff (!aresetn)
        good_r |-> (len_r[2:0] == 3'h0 && cnt_r == len_r && len_r >= PAY_MIN_LEN))
        else $error("Good payload length is not a valid multiple of eight.");
    chk_good_sum_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        good_r |-> (sum_r == 8'h00 && !err_r))
        else $error("Payload judged good without a zero sum.");
endmodule : swd_pay_chk

/* File: rtl/swd_disc.sv */
// Discovery initiator for single-wire sideband targets with an AXI4-Lite register file.
//
// Contract
// - Flag possible backfeed when a wire is statically low and firmware did not account it.
// - With fetch and exchange enabled, break release triggers an automatic payload request.
// - A good payload sets the state to payload good and stays readable.
// - Good payload plus exchange enable starts the hardware virtual wire exchange.
// - Success needs no timeout, no parity or framing error, and a verified checksum.
// - No target enters the active phase before a good payload.
// - Retry while present and fetch enabled; clearing fetch enable stops attempts.
// - Shared initiator: initial attempt plus two retries, then the next target.
// - Header byte 0Ah: wire counts with reserved zero bit 3.
// - State codes: 00 high, 01 low, 10 payload good, 11 break released.
// - Requests only while fetch enable is 1, stopping at payload good.
// - Exchange only when exchange enable is 1 and state is payload good.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module swd_disc #(
    parameter int unsigned RX_TIMEOUT_CYC = swd_pkg::RX_TIMEOUT_CYC
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    ce,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic [swd_pkg::NT-1:0]  wire_in,
    output logic                         tx_valid,
    input  wire logic                    tx_ready,
    output logic [7:0]                   tx_byte,
    output logic                         link_sel,
    input  wire logic                    rx_valid,
    input  wire logic [7:0]              rx_byte,
    input  wire logic                    rx_err,
    output logic [swd_pkg::NT-1:0]       exchange_en,
    output logic [swd_pkg::NT-1:0]       backfeed
);
    import swd_pkg::*;

    // Register file and AXI state.
    logic [NT-1:0]     fetch_en_r, fetch_en_nxt, active_en_r, active_en_nxt, acct_r, acct_nxt;
    logic              aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt, bvalid_r, bvalid_nxt;
    logic              rvalid_r, rvalid_nxt;
    logic [7:0]        awaddr_r, awaddr_nxt;
    logic [31:0]       wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic [3:0]        wstrb_r, wstrb_nxt;
    logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    // Wire sampling and discovery state.
    logic [NT-1:0]     s1_r, s2_r, s3_r, lvl_r, lvl_nxt, exch_r, exch_nxt, bf_r, bf_nxt;
    logic [NT-1:0][1:0] disc_r, disc_nxt;
    logic [NT-1:0]     need;
    // Sequencer.
    swd_seq_t          seq_r, seq_nxt;
    logic              sel_r, sel_nxt;
    logic [1:0]        tries_r, tries_nxt;
    logic [26:0]       tmr_r, tmr_nxt;
    logic              chk_start, chk_done, chk_good, pay_ok;
    logic [10:0]       chk_idx;
    logic [7:0]        pay_r [NT*PAY_BYTES];

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes; address and data are taken in either order.
    assign s_axi_awready = ce && !aw_hold_r && !bvalid_r;
    assign s_axi_wready  = ce && !w_hold_r && !bvalid_r;
    assign s_axi_arready = ce && !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // Payload window decode for both paths; addresses past the last target do not alias into it.
    function automatic logic pay_addr(input logic [7:0] a);
        return a >= REG_PAY_BASE && a < 8'(REG_PAY_BASE + NT * PAY_BYTES) && a[1:0] == 2'h0;
    endfunction : pay_addr

    // Write path, read path and control register next values.
    always_comb begin
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic [5:0]  bi;
        wa = s_axi_awvalid && s_axi_awready ? s_axi_awaddr : awaddr_r;
        wd = s_axi_wvalid && s_axi_wready ? s_axi_wdata : wdata_r;
        ws = s_axi_wvalid && s_axi_wready ? s_axi_wstrb : wstrb_r;
        bi = '0;
        aw_hold_nxt   = aw_hold_r || (s_axi_awvalid && s_axi_awready);
        w_hold_nxt    = w_hold_r || (s_axi_wvalid && s_axi_wready);
        awaddr_nxt    = wa;
        wdata_nxt     = wd;
        wstrb_nxt     = ws;
        bvalid_nxt    = bvalid_r && !s_axi_bready;
        bresp_nxt     = bresp_r;
        fetch_en_nxt  = fetch_en_r;
        active_en_nxt = active_en_r;
        acct_nxt      = acct_r;
        if (aw_hold_nxt && w_hold_nxt && !bvalid_r) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = RESP_OKAY;
            if (wa == REG_CTRL) begin
                if (ws[0]) begin
                    fetch_en_nxt  = wd[CTRL_FETCH_POS +: NT];
                    active_en_nxt = wd[CTRL_ACTIVE_POS +: NT];
                end
                if (ws[1]) begin
                    acct_nxt = wd[CTRL_ACCT_POS +: NT];
                end
            end else if (wa != REG_STATUS && !pay_addr(wa)) begin
                bresp_nxt = RESP_SLVERR;
            end
        end
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            if (s_axi_araddr == REG_CTRL) begin
                rdata_nxt[CTRL_FETCH_POS +: NT]  = fetch_en_r;
                rdata_nxt[CTRL_ACTIVE_POS +: NT] = active_en_r;
                rdata_nxt[CTRL_ACCT_POS +: NT]   = acct_r;
            end else if (s_axi_araddr == REG_STATUS) begin
                rdata_nxt[2*NT-1:0]               = disc_r;
                rdata_nxt[ST_EXCH_POS +: NT]     = exch_r;
                rdata_nxt[ST_BACKFEED_POS +: NT] = bf_r;
                rdata_nxt[ST_BUSY_POS]           = seq_r != SEQ_IDLE;
            end else if (pay_addr(s_axi_araddr)) begin
                bi        = 6'(s_axi_araddr - REG_PAY_BASE);
                rdata_nxt = {pay_r[bi + 6'h03], pay_r[bi + 6'h02], pay_r[bi + 6'h01], pay_r[bi]};
            end else begin
                rresp_nxt = RESP_SLVERR;
            end
        end
    end

    // AXI and control registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r   <= 1'b0;
            w_hold_r    <= 1'b0;
            awaddr_r    <= '0;
            wdata_r     <= '0;
            wstrb_r     <= '0;
            bvalid_r    <= 1'b0;
            bresp_r     <= RESP_OKAY;
            rvalid_r    <= 1'b0;
            rdata_r     <= '0;
            rresp_r     <= RESP_OKAY;
            fetch_en_r  <= '0;
            active_en_r <= '0;
            acct_r      <= '0;
        end else if (ce) begin
            aw_hold_r   <= aw_hold_nxt;
            w_hold_r    <= w_hold_nxt;
            awaddr_r    <= awaddr_nxt;
            wdata_r     <= wdata_nxt;
            wstrb_r     <= wstrb_nxt;
            bvalid_r    <= bvalid_nxt;
            bresp_r     <= bresp_nxt;
            rvalid_r    <= rvalid_nxt;
            rdata_r     <= rdata_nxt;
            rresp_r     <= rresp_nxt;
            fetch_en_r  <= fetch_en_nxt;
            active_en_r <= active_en_nxt;
            acct_r      <= acct_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wire level, discovery state, exchange and backfeed next values.
    assign pay_ok = chk_done && chk_good && seq_r == SEQ_WAIT;
    always_comb begin
        for (int t = 0; t < NT; t++) begin
            // A level change counts once the second and third samples agree.
            lvl_nxt[t]   = (s2_r[t] == s3_r[t]) ? s3_r[t] : lvl_r[t];
            disc_nxt[t] = disc_r[t];
            // state encoding; the active phase locks payload good
            if (!exch_r[t] && lvl_nxt[t] != lvl_r[t]) begin
                disc_nxt[t] = lvl_nxt[t] ? DS_RELEASED : DS_LOW;
            end else if (pay_ok && sel_r == t[0] && lvl_r[t]) begin
                disc_nxt[t] = DS_GOOD;
            end else if (fetch_en_nxt[t] && !fetch_en_r[t] && !active_en_r[t] && disc_r[t] == DS_GOOD) begin
                disc_nxt[t] = DS_RELEASED;
            end
            // exchange needs enable and good payload
            exch_nxt[t] = active_en_r[t] && disc_r[t] == DS_GOOD;
            bf_nxt[t]   = disc_r[t] == DS_LOW && !acct_r[t];
            // fetch only when enabled and not yet good
            need[t]     = fetch_en_r[t] && disc_r[t] == DS_RELEASED && lvl_r[t];
        end
    end

    // Three-flop wire samplers and per-target state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r    <= '1;
            s2_r    <= '1;
            s3_r    <= '1;
            lvl_r   <= '1;
            disc_r  <= {NT{DS_HIGH}};
            exch_r  <= '0;
            bf_r    <= '0;
        end else if (ce) begin
            s1_r    <= wire_in;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            lvl_r   <= lvl_nxt;
            disc_r  <= disc_nxt;
            exch_r  <= exch_nxt;
            bf_r    <= bf_nxt;
        end
    end

    assign exchange_en = exch_r;
    assign backfeed    = bf_r;

    ////////////////////////////////////////////////////////////////////////////
    // Request sequencer with round-robin target servicing.
    assign tx_valid  = seq_r == SEQ_SEND && need[sel_r];
    assign tx_byte   = PAY_REQ_CMD;
    assign link_sel  = sel_r;
    assign chk_start = tx_valid && tx_ready;
    always_comb begin
        seq_nxt   = seq_r;
        sel_nxt   = sel_r;
        tries_nxt = tries_r;
        tmr_nxt   = tmr_r + 27'h1;
        unique case (seq_r)
            SEQ_IDLE: begin
                if (need[sel_r]) begin
                    seq_nxt = SEQ_SEND;
                end else begin
                    sel_nxt   = !sel_r;
                    tries_nxt = '0;
                end
            end
            SEQ_SEND: begin
                tmr_nxt = '0;
                if (!need[sel_r]) begin
                    seq_nxt = SEQ_IDLE;
                end else if (tx_ready) begin
                    seq_nxt = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                // timeout, success test, stop when disabled
                if (pay_ok) begin
                    seq_nxt   = SEQ_IDLE;
                    tries_nxt = '0;
                end else if (chk_done || tmr_r == 27'(RX_TIMEOUT_CYC - 1) || !need[sel_r]) begin
                    seq_nxt = SEQ_IDLE;
                    if (tries_r == 2'(RETRIES)) begin
                        tries_nxt = '0;
                        sel_nxt   = !sel_r;
                    end else begin
                        tries_nxt = tries_r + 2'h1;
                    end
                end
            end
        endcase
    end

    // Sequencer registers and payload capture.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_r   <= SEQ_IDLE;
            sel_r   <= 1'b0;
            tries_r <= '0;
            tmr_r   <= '0;
        end else if (ce) begin
            seq_r   <= seq_nxt;
            sel_r   <= sel_nxt;
            tries_r <= tries_nxt;
            tmr_r   <= tmr_nxt;
            if (seq_r == SEQ_WAIT && rx_valid && chk_idx < 11'(PAY_BYTES)) begin
                pay_r[{sel_r, chk_idx[4:0]}] <= rx_byte;
            end
        end
    end

    // Payload byte counting and checksum.
    swd_pay_chk u_chk (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ce       (ce),
        .start    (chk_start),
        .rx_valid (rx_valid && seq_r == SEQ_WAIT),
        .rx_byte  (rx_byte),
        .rx_err   (rx_err),
        .done     (chk_done),
        .good     (chk_good),
        .idx      (chk_idx)
    );

    chk_exch_needs_good: assert property (@(posedge aclk) disable iff (!aresetn)
        exch_r[0] |-> disc_r[0] == DS_GOOD && active_en_r[0])
        else $error("Exchange enabled without a good payload.");
    chk_req_when_need: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_valid |-> fetch_en_r[sel_r] && disc_r[sel_r] == DS_RELEASED)
        else $error("Payload request sent while not needed.");
    chk_auto_request: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && seq_r == SEQ_IDLE && need[sel_r]) |=> tx_valid)
        else $error("Released target was not requested.");
    chk_good_sets_state: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && pay_ok && lvl_r[sel_r] && !exch_r[sel_r] && lvl_nxt[sel_r]) |=> disc_r[$past(sel_r)] == DS_GOOD)
        else $error("Good payload did not set payload good.");
    chk_timeout_ends: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && seq_r == SEQ_WAIT && tmr_r == 27'(RX_TIMEOUT_CYC - 1)) |=> seq_r == SEQ_IDLE)
        else $error("Wait did not end at timeout.");
    chk_retry_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        tries_r <= 2'(RETRIES))
        else $error("More than two retries for one target.");
    chk_backfeed_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && disc_r[0] == DS_LOW && !acct_r[0]) |=> backfeed[0])
        else $error("Unaccounted low wire not flagged.");
    chk_exch_starts: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && active_en_r[1] && disc_r[1] == DS_GOOD) |=> exchange_en[1])
        else $error("Exchange did not start after good payload.");
endmodule : swd_disc

/* File: dv/swd_tgt_model.sv */
// Behavioural sideband target that answers payload requests on the shared link.
`timescale 1ns/10ps
module swd_tgt_model (
    input  wire logic       aclk,
    input  wire logic [1:0] mode,
    input  wire logic       tx_valid,
    input  wire logic       link_sel,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            rx_err,
    output int              req_n1
);
    logic [7:0] pay [16];
    logic [1:0] md;
    // Mode 0 answers well, 1 spoils the checksum, 2 flags a byte error, 3 stays silent.
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h5A;
        rx_err = 1'b0;
        req_n1 = 0;
        pay = '{2: 8'h02, 10: 8'h41, 11: 8'h02, 15: 8'hBB, default: 8'h00};
        forever begin
            @(negedge aclk);
            if (tx_valid) begin
                // Mode is latched per request so that a change cannot mix two faults in one answer.
                md = mode;
                @(posedge aclk);
                tx_ready <= 1'b1;
                @(posedge aclk);
                tx_ready <= 1'b0;
                req_n1 <= req_n1 + link_sel;
                repeat (13) @(posedge aclk);
                // bytes with idle gaps, data line inverted between bytes.
                for (int i = 0; i < 16 && md != 2'h3; i++) begin
                    rx_valid <= 1'b1;
                    rx_byte <= pay[i] ^ {7'h00, md == 2'h1 && i == 15};
                    rx_err <= md == 2'h2 && i == 5;
                    @(posedge aclk);
                    rx_valid <= 1'b0;
                    rx_byte <= ~pay[i];
                    rx_err <= 1'b0;
                    @(posedge aclk);
                end
            end
        end
    end
endmodule : swd_tgt_model

/* File: dv/swd_disc_tb.sv */
// Self-checking bench for the discovery initiator with a behavioural target.
`timescale 1ns/10ps
module swd_disc_tb;
    import swd_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, tx_byte, rx_byte;
    logic [31:0] wdata = 32'h0, d, rdata_w;
    logic [1:0]  wire_in = 2'b11, mode = 2'h0, bresp, rresp, r, exchange_en, backfeed;
    logic        awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, link_sel, rx_valid, rx_err;
    int          err_count = 0, tests_run = 0, n, n1;
    // Free-running 125 MHz clock.
    always #4 aclk = ~aclk;
    // Design with a short receive timeout, and the target on its link.
    swd_disc #(.RX_TIMEOUT_CYC(200)) dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata_w), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .wire_in(wire_in), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte), .link_sel(link_sel),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_err(rx_err), .exchange_en(exchange_en), .backfeed(backfeed));
    swd_tgt_model tgt (.aclk(aclk), .mode(mode), .tx_valid(tx_valid), .link_sel(link_sel), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_err(rx_err), .req_n1(n1));
    // Compare and count.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One write; both channels offered together, each released when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] rs);
        logic ah, wh, bh;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bvalid;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end while (!bh);
        chk(bresp, rs);
    endtask : wr
    // Reads until the masked value matches or the try limit runs out, then compares.
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] rs);
        logic ah, rh;
        for (int k = 0; k < 400 && (k == 0 || (d & m) !== e); k++) begin
            araddr <= a;
            arvalid <= 1'b1;
            do begin
                @(negedge aclk);
                ah = arvalid & arready;
                rh = rvalid;
                d = rdata_w;
                r = rresp;
                @(posedge aclk);
                if (ah) arvalid <= 1'b0;
            end while (!rh);
        end
        chk(d & m, e);
        chk(r, rs);
    endtask : rd
    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    // Main sequence.
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(REG_STATUS, 32'hFFFF_FFFF, 32'h0, RESP_OKAY);
        wr(8'h08, 32'h33, RESP_SLVERR);
        rd(REG_CTRL, 32'hFFFF_FFFF, 32'h0, RESP_OKAY);
        $display("Test reset_map done");
        wire_in[0] <= 1'b0;
        rd(REG_STATUS, 32'h1003, 32'h1001, RESP_OKAY);
        wr(REG_CTRL, 32'h133, RESP_OKAY);
        rd(REG_STATUS, 32'h1003, 32'h0001, RESP_OKAY);
        wire_in[0] <= 1'b1;
        rd(REG_STATUS, 32'h0303, 32'h0102, RESP_OKAY);
        chk(exchange_en, 32'h1);
        rd(8'h48, 32'hFFFF_FFFF, 32'h0241_0000, RESP_OKAY);
        rd(8'h4C, 32'hFFFF_FFFF, 32'hBB00_0000, RESP_OKAY);
        rd(8'h80, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
        $display("Test express done");
        wire_in[1] <= 1'b0;
        rd(REG_STATUS, 32'h300C, 32'h2004, RESP_OKAY);
        chk(backfeed, 32'h2);
        wire_in[1] <= 1'b1;
        for (int m = 1; m < 4; m++) begin
            mode <= m[1:0];
            n = n1;
            repeat (900) @(posedge aclk);
            chk(n1 > n + 2, 1'b1);
            rd(REG_STATUS, 32'h030C, 32'h010C, RESP_OKAY);
        end
        wr(REG_CTRL, 32'h131, RESP_OKAY);
        repeat (300) @(posedge aclk);
        n = n1;
        repeat (600) @(posedge aclk);
        chk(n1, n);
        mode <= 2'h0;
        wr(REG_CTRL, 32'h133, RESP_OKAY);
        rd(REG_STATUS, 32'h030C, 32'h0308, RESP_OKAY);
        chk(exchange_en, 32'h3);
        chk(tx_valid, 32'h0);
        chk(tx_byte, PAY_REQ_CMD);
        $display("Test retry done");
        complete_run();
    end
    // Watchdog against a hang.
    initial begin
        repeat (30000) @(posedge aclk);
        err_count++;
        complete_run();
    end
endmodule : swd_disc_tb
